// *** qrbsp_cclk_model.sv ***
// Controller side output clock pair, held high for single clock mode
`timescale 1ns/1ns
`default_nettype none
module qrbsp_cclk_model #(
  parameter bit SINGLE = 1'b1  // Fixed from power-up, never switched
) (
  input  wire logic clk,       // Word clock
  output logic      out_clk,   // C level
  output logic      out_clk_n  // C-bar level
);
  logic c = 1'b0;
  always @(negedge clk) c <= ~c;
  assign out_clk   = SINGLE | c;
  assign out_clk_n = SINGLE | ~c;
endmodule : qrbsp_cclk_model
`default_nettype wire

// *** qrbsp_mem_array.sv ***
// Flip-flop storage array with per-lane write enables and combinational read
`timescale 1ns/1ns
`default_nettype none
module qrbsp_mem_array
  import qrbsp_pkg::*;
(
  input  wire logic              clk,      // Word clock
  input  wire logic              wr_en,    // Write one word this edge
  input  wire logic [ADDR_W-1:0] wr_addr,  // Write word address
  input  wire logic [DATA_W-1:0] wr_data,  // Write data
  input  wire logic [LANES-1:0]  wr_lanes, // Lanes to update
  input  wire logic [ADDR_W-1:0] rd_addr,  // Read word address
  output logic      [DATA_W-1:0] rd_data   // Read data
);

  logic [DATA_W-1:0] mem [DEPTH];

  assign rd_data = mem[rd_addr];

  // Disabled lanes keep their old contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lanes[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule : qrbsp_mem_array
`default_nettype wire

// *** qrbsp_monitor.sv ***
// Port checker for the burst SRAM port
`timescale 1ns/1ns
`default_nettype none
module qrbsp_monitor
  import qrbsp_pkg::*;
(
  input wire logic              clk,               // Clock
  input wire logic              srst,              // Reset
  input wire logic              clock_run,         // Run request
  input wire logic              out_clk,           // C
  input wire logic              out_clk_n,         // C-bar
  input wire logic              read_sel_n,        // Read select
  input wire logic              write_sel_n,       // Write select
  input wire logic [DATA_W-1:0] q,                 // Read data
  input wire logic              q_oe,              // Read data driven
  input wire logic              clock_stopped,     // Stop honoured
  input wire logic              impedance_update,  // Idle slot
  input wire logic              impedance_settled  // Settled
);
  logic        phd;
  logic [2:0]  rcnt;
  logic [2:0]  wcnt;
  logic [10:0] kcnt;
  // Stop flag is high exactly when the edge before it froze the phase, so phase is rebuilt here
  wire ph    = phd ^ !clock_stopped;
  // Port runs while the clock runs, a burst is busy or a word is still on q
  wire busy  = clock_run || rcnt != 3'h0 || wcnt != 3'h0 || q_oe;
  // Commands count only on K edges when idle or in the last two beats
  wire rd_go = !ph && !read_sel_n && (rcnt == 3'h0 || rcnt == 3'h2) && busy;
  wire wr_go = !ph && !write_sel_n && (wcnt == 3'h0 || wcnt == 3'h2) && busy;
  always_ff @(posedge clk) begin
    phd  <= srst ? 1'b1 : phd ^ !clock_stopped;
    rcnt <= srst ? 3'h0 : rd_go ? 3'h5 : rcnt - 3'(rcnt != 3'h0);
    wcnt <= srst ? 3'h0 : wr_go ? 3'h5 : wcnt - 3'(wcnt != 3'h0);
    kcnt <= srst ? 11'h000 : kcnt + 11'(!ph && busy && !rd_go && kcnt != 11'h7ff);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_burst; q_oe [*4]; endsequence
  sequence s_quiet; !q_oe [*3]; endsequence
  property p_rd_lat; rd_go && out_clk && out_clk_n |-> ##3 s_burst; endproperty
  // Two clock mode loads q from the registered rd_word, which adds one edge of lag
  property p_rd_lat_n; rd_go && !(out_clk && out_clk_n) |-> ##4 s_burst; endproperty
  property p_idle_off;
    rcnt == 3'h0 && $past(rcnt) == 3'h0 && ((out_clk && out_clk_n) || $past(rcnt, 2) == 3'h0)
      |-> !q_oe;
  endproperty
  property p_wr_quiet; wr_go && !rd_go && rcnt == 3'h0 && !q_oe |=> s_quiet; endproperty
  property p_stop; clock_stopped |-> rcnt == 3'h0 && wcnt == 3'h0 && !q_oe; endproperty
  property p_stop_go; !busy |=> clock_stopped; endproperty
  property p_stop_hold; clock_stopped && $past(clock_stopped) |-> $stable(q) && $stable(q_oe);
  endproperty
  property p_run; clock_run |=> !clock_stopped; endproperty
  property p_imp; impedance_update |-> !q_oe; endproperty
  property p_settle; kcnt < 11'h400 |-> !impedance_settled; endproperty
  property p_settle_on; kcnt >= 11'h400 |-> impedance_settled; endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read burst late or short");
  a_rd_lat_n: assert property (p_rd_lat_n)
    else $error("read burst late or short in two clock mode");
  a_idle_off: assert property (p_idle_off)
    else $error("outputs driven while deselected");
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("write drove read outputs");
  a_stop: assert property (p_stop)
    else $error("stopped with a burst pending");
  a_stop_go: assert property (p_stop_go)
    else $error("idle stop not honoured");
  a_stop_hold: assert property (p_stop_hold)
    else $error("outputs moved while stopped");
  a_run: assert property (p_run)
    else $error("stop flag stayed with clock running");
  a_imp: assert property (p_imp)
    else $error("impedance update while driving");
  a_settle: assert property (p_settle)
    else $error("settled too early");
  a_settle_on: assert property (p_settle_on)
    else $error("not settled after enough non-read cycles");
endmodule : qrbsp_monitor
`default_nettype wire

// *** qrbsp_pkg.sv ***
// Constants, stage encoding and shared helpers for the burst SRAM port
package qrbsp_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES  = 4;
  localparam int DEPTH  = 1048576;

  localparam logic [3:0] LANES_WIDE   = 4'hf;
  localparam logic [3:0] LANES_NARROW = 4'h3;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int IMP_SETTLE_CYC = 1024;
  localparam int IMP_CNT_W      = 11;
  localparam logic [IMP_CNT_W-1:0] IMP_SETTLE_CNT = 11'h400;
  localparam logic [IMP_CNT_W-1:0] IMP_CNT_RESET  = 11'h000;
  localparam logic                 PHASE_RESET    = 1'b0;

  typedef enum logic [5:0] {
    QRBSP_IDLE  = 6'h01,
    QRBSP_GAP   = 6'h02,
    QRBSP_BEAT0 = 6'h04,
    QRBSP_BEAT1 = 6'h08,
    QRBSP_BEAT2 = 6'h10,
    QRBSP_BEAT3 = 6'h20
  } qrbsp_stage_t;

  // Stage after this edge; a command queued at BEAT2 chains straight into BEAT0
  function automatic qrbsp_stage_t qrbsp_next_stage(input qrbsp_stage_t s,
                                                    input logic take,
                                                    input logic pend);
    case (s)
      QRBSP_IDLE:  return take ? QRBSP_GAP : QRBSP_IDLE;
      QRBSP_GAP:   return QRBSP_BEAT0;
      QRBSP_BEAT0: return QRBSP_BEAT1;
      QRBSP_BEAT1: return QRBSP_BEAT2;
      QRBSP_BEAT2: return QRBSP_BEAT3;
      QRBSP_BEAT3: return pend ? QRBSP_BEAT0 : QRBSP_IDLE;
      default:     return QRBSP_IDLE;
    endcase
  endfunction : qrbsp_next_stage

  function automatic logic qrbsp_is_beat(input qrbsp_stage_t s);
    return (s == QRBSP_BEAT0) || (s == QRBSP_BEAT1) ||
           (s == QRBSP_BEAT2) || (s == QRBSP_BEAT3);
  endfunction : qrbsp_is_beat

  function automatic logic [1:0] qrbsp_beat_idx(input qrbsp_stage_t s);
    case (s)
      QRBSP_BEAT1: return 2'h1;
      QRBSP_BEAT2: return 2'h2;
      QRBSP_BEAT3: return 2'h3;
      default:     return 2'h0;
    endcase
  endfunction : qrbsp_beat_idx

  // Low two bits wrap as a linear counter from the supplied address
  function automatic logic [ADDR_W-1:0] qrbsp_burst_addr(input logic [ADDR_W-1:0] base,
                                                        input logic [1:0] idx);
    logic [1:0] low;
    low = base[1:0] + idx;
    return {base[ADDR_W-1:2], low};
  endfunction : qrbsp_burst_addr

endpackage : qrbsp_pkg

// *** qrbsp_port.sv ***
// Burst SRAM core: read and write burst sequencers, output timing, clock stop
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Read select low at K edge captures address
// - Four words per read, 36 or 18 bits
// - First word after next K edge, then alternating
// - Back-to-back reads give data every edge
// - Output clocks high: time outputs from K
// - After read ends, finish burst, then tristate
// - Write select low at K edge captures address
// - Four write words over next two cycles
// - Continuous writes register every edge word
// - Input data ignored without write select
// - Two-bit linear burst address counter
// - Independent read and write sequencers on K
// - Clock stop waits for bursts, then holds
// - Narrow: lanes 0 and 1 gate bits
// - Wide: lanes 2 and 3 gate upper bits
// - Lane enables sampled per word; high keeps
// - Impedance updates only while outputs idle
// - Ports select and deselect independently
// - Command during own burst is ignored, except in its last K cycle (BEAT2), where it is queued
module qrbsp_port
  import qrbsp_pkg::*;
#(
  parameter bit WIDE_ORG = 1'b1  // 1: 36-bit words, 0: 18-bit words
) (
  input  wire logic              clk,              // Word clock, K and K-bar edges
  input  wire logic              srst,             // Synchronous reset, active high
  input  wire logic              clock_run,        // High while the input clock pair runs
  input  wire logic              out_clk,          // Output clock C, sampled
  input  wire logic              out_clk_n,        // Output clock C-bar, sampled
  input  wire logic              read_sel_n,       // Read select, active low
  input  wire logic              write_sel_n,      // Write select, active low
  input  wire logic [ADDR_W-1:0] shared_address,   // Shared read/write address
  input  wire logic [DATA_W-1:0] d,                // Write data
  input  wire logic              byte_write_en0_n, // Lane 0 write enable, active low
  input  wire logic              byte_write_en1_n, // Lane 1 write enable, active low
  input  wire logic              byte_write_en2_n, // Lane 2 write enable, active low
  input  wire logic              byte_write_en3_n, // Lane 3 write enable, active low
  output logic      [DATA_W-1:0] q,                // Read data
  output logic                   q_oe,             // Read data driven
  output logic                   clock_stopped,    // Clock stop honoured
  output logic                   impedance_update, // Impedance update this cycle
  output logic                   impedance_settled // Enough non-read cycles seen
);

  qrbsp_stage_t      rd_stage;
  qrbsp_stage_t      wr_stage;
  qrbsp_stage_t      next_rd_stage;
  qrbsp_stage_t      next_wr_stage;
  logic [ADDR_W-1:0] rd_base;
  logic [ADDR_W-1:0] rd_pend;
  logic              rd_pend_vld;
  logic [ADDR_W-1:0] wr_base;
  logic [ADDR_W-1:0] wr_pend;
  logic              wr_pend_vld;
  logic              phase;
  logic              mode_caught;
  logic              single_mode;
  logic              out_clk_q;
  logic              out_clk_n_q;
  logic [DATA_W-1:0] rd_word;
  logic              rd_valid;
  logic [IMP_CNT_W-1:0] imp_cnt;

  wire logic [LANES-1:0]  org_lanes;
  wire logic [LANES-1:0]  bw_n;
  wire logic [LANES-1:0]  wr_lanes;
  wire logic              both_idle;
  wire logic              run;
  wire logic              k_edge;
  wire logic              rd_open;
  wire logic              wr_open;
  wire logic              rd_take;
  wire logic              wr_take;
  wire logic              rd_beat;
  wire logic              wr_beat;
  wire logic [ADDR_W-1:0] rd_addr;
  wire logic [ADDR_W-1:0] wr_addr;
  wire logic [DATA_W-1:0] mem_rd_data;
  wire logic [DATA_W-1:0] next_rd_word;
  wire logic              next_rd_valid;
  wire logic              out_strobe;
  wire logic              wr_en;
  wire logic              outputs_idle;

  assign org_lanes = WIDE_ORG ? LANES_WIDE : LANES_NARROW;
  assign bw_n      = {byte_write_en3_n, byte_write_en2_n, byte_write_en1_n, byte_write_en0_n};
  // Upper lanes exist only in the wide organisation
  assign wr_lanes  = ~bw_n & org_lanes;

  assign both_idle = (rd_stage == QRBSP_IDLE) && (wr_stage == QRBSP_IDLE);
  // A stop waits for both bursts and for the last read word to leave q, so none is stranded
  assign run       = clock_run || !both_idle || rd_valid || q_oe;
  assign k_edge    = (phase == PHASE_RESET);

  // A command is taken when idle, or in the last K cycle of a burst so data stays gapless
  assign rd_open = (rd_stage == QRBSP_IDLE) || (rd_stage == QRBSP_BEAT2);
  assign wr_open = (wr_stage == QRBSP_IDLE) || (wr_stage == QRBSP_BEAT2);
  assign rd_take = run && k_edge && !read_sel_n && rd_open;
  assign wr_take = run && k_edge && !write_sel_n && wr_open;

  // Separate sequencers, each stepped on the same edges
  assign next_rd_stage = qrbsp_next_stage(rd_stage, rd_take, rd_pend_vld);
  assign next_wr_stage = qrbsp_next_stage(wr_stage, wr_take, wr_pend_vld);

  assign rd_beat = qrbsp_is_beat(rd_stage);
  assign wr_beat = qrbsp_is_beat(wr_stage);
  assign rd_addr = qrbsp_burst_addr(rd_base, qrbsp_beat_idx(rd_stage));
  assign wr_addr = qrbsp_burst_addr(wr_base, qrbsp_beat_idx(wr_stage));

  // Data is taken only in write beats, so idle-cycle data never lands
  assign wr_en = run && wr_beat && (wr_lanes != 4'h0);

  assign next_rd_word  = rd_beat ? (mem_rd_data & {{LANE_W{org_lanes[3]}}, {LANE_W{org_lanes[2]}},
                                                  {LANE_W{org_lanes[1]}}, {LANE_W{org_lanes[0]}}})
                                 : rd_word;
  assign next_rd_valid = rd_beat;

  assign out_strobe   = (out_clk && !out_clk_q) || (out_clk_n && !out_clk_n_q);
  assign outputs_idle = !q_oe && !rd_valid && (rd_stage == QRBSP_IDLE);

  qrbsp_mem_array u_mem (
    .clk      (clk),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (d),
    .wr_lanes (wr_lanes),
    .rd_addr  (rd_addr),
    .rd_data  (mem_rd_data)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= PHASE_RESET;
    end else if (run) begin
      phase <= ~phase;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_stage    <= QRBSP_IDLE;
      rd_pend_vld <= 1'b0;
      rd_base     <= '0;
      rd_pend     <= '0;
    end else if (run) begin
      rd_stage <= next_rd_stage;
      if (rd_take && rd_stage == QRBSP_IDLE) begin
        rd_base <= shared_address;
      end else if (rd_take) begin
        rd_pend     <= shared_address;
        rd_pend_vld <= 1'b1;
      end else if (rd_stage == QRBSP_BEAT3 && rd_pend_vld) begin
        rd_base     <= rd_pend;
        rd_pend_vld <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_stage    <= QRBSP_IDLE;
      wr_pend_vld <= 1'b0;
      wr_base     <= '0;
      wr_pend     <= '0;
    end else if (run) begin
      wr_stage <= next_wr_stage;
      if (wr_take && wr_stage == QRBSP_IDLE) begin
        wr_base <= shared_address;
      end else if (wr_take) begin
        wr_pend     <= shared_address;
        wr_pend_vld <= 1'b1;
      end else if (wr_stage == QRBSP_BEAT3 && wr_pend_vld) begin
        wr_base     <= wr_pend;
        wr_pend_vld <= 1'b0;
      end
    end
  end

  // Mode is caught once after reset; a later change of the output clocks is not followed
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_caught <= 1'b0;
      single_mode <= 1'b0;
    end else if (!mode_caught) begin
      mode_caught <= 1'b1;
      single_mode <= out_clk && out_clk_n;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_clk_q   <= 1'b0;
      out_clk_n_q <= 1'b0;
    end else begin
      out_clk_q   <= out_clk;
      out_clk_n_q <= out_clk_n;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_word  <= '0;
      rd_valid <= 1'b0;
    end else if (run) begin
      rd_word  <= next_rd_word;
      rd_valid <= next_rd_valid;
    end
  end

  // Stopped clock leaves q and q_oe at their last values
  always_ff @(posedge clk) begin
    if (srst) begin
      q    <= '0;
      q_oe <= 1'b0;
    end else if (run && single_mode) begin
      q    <= next_rd_word;
      q_oe <= next_rd_valid;
    end else if (run && out_strobe) begin
      q    <= rd_word;
      q_oe <= rd_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clock_stopped <= 1'b0;
    end else begin
      clock_stopped <= !run;
    end
  end

  // Updates ride only on cycles with nothing driven, so access timing never moves
  always_ff @(posedge clk) begin
    if (srst) begin
      impedance_update <= 1'b0;
    end else begin
      impedance_update <= run && outputs_idle && !rd_take;
    end
  end

  // Counts non-read K cycles up to the settle figure, then saturates
  always_ff @(posedge clk) begin
    if (srst) begin
      imp_cnt <= IMP_CNT_RESET;
    end else if (run && k_edge && !rd_take && imp_cnt != IMP_SETTLE_CNT) begin
      imp_cnt <= imp_cnt + 11'h001;
    end
  end

  assign impedance_settled = (imp_cnt == IMP_SETTLE_CNT);

endmodule : qrbsp_port
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import qrbsp_pkg::*;
  logic              clk, srst, clock_run, read_sel_n, write_sel_n, out_clk, out_clk_n;
  logic [ADDR_W-1:0] shared_address;
  logic [DATA_W-1:0] d, q;
  logic [3:0]        bw_n;
  logic              q_oe, clock_stopped, impedance_update, impedance_settled;
  logic [DATA_W-1:0] q_n;
  logic              q_oe_n, nm_out_clk, nm_out_clk_n;
  logic [ADDR_W-1:0] a [4];
  logic [DATA_W-1:0] mem [int];
  int                fails = 0, n_tests = 0;
  // Narrow organisation keeps lanes 0 and 1 only
  localparam logic [DATA_W-1:0] NARROW_MASK = 36'h00003ffff;
  qrbsp_cclk_model #(.SINGLE(1'b1)) u_cclk (.clk(clk), .out_clk(out_clk), .out_clk_n(out_clk_n));
  qrbsp_port #(.WIDE_ORG(1'b1)) uut (.clk(clk), .srst(srst), .clock_run(clock_run),
    .out_clk(out_clk), .out_clk_n(out_clk_n), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .shared_address(shared_address), .d(d),
    .byte_write_en0_n(bw_n[0]), .byte_write_en1_n(bw_n[1]), .byte_write_en2_n(bw_n[2]),
    .byte_write_en3_n(bw_n[3]), .q(q), .q_oe(q_oe), .clock_stopped(clock_stopped),
    .impedance_update(impedance_update), .impedance_settled(impedance_settled));
  // Second port: narrow words, output clock pair running
  qrbsp_cclk_model #(.SINGLE(1'b0)) u_cclk_n (.clk(clk), .out_clk(nm_out_clk),
    .out_clk_n(nm_out_clk_n));
  qrbsp_port #(.WIDE_ORG(1'b0)) uut_n (.clk(clk), .srst(srst), .clock_run(clock_run),
    .out_clk(nm_out_clk), .out_clk_n(nm_out_clk_n), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .shared_address(shared_address), .d(d),
    .byte_write_en0_n(bw_n[0]), .byte_write_en1_n(bw_n[1]), .byte_write_en2_n(bw_n[2]),
    .byte_write_en3_n(bw_n[3]), .q(q_n), .q_oe(q_oe_n), .clock_stopped(),
    .impedance_update(), .impedance_settled());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic int ba(input logic [ADDR_W-1:0] b, input int i);
    return int'({b[ADDR_W-1:2], 2'(b[1:0] + 2'(i))});
  endfunction : ba
  // Called just after a falling edge that precedes a K edge; returns likewise
  task automatic wr(input logic [ADDR_W-1:0] b, input bit lanes);
    logic [DATA_W-1:0] w, m;
    write_sel_n = 1'b0;
    shared_address = b;
    @(negedge clk) write_sel_n = 1'b1;
    shared_address = ADDR_W'($urandom());
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) w = DATA_W'({$urandom(), $urandom()});
      bw_n = lanes ? 4'($urandom()) : 4'h0;
      d = w;
      m = mem.exists(ba(b, i)) ? mem[ba(b, i)] : w;
      for (int k = 0; k < LANES; k++) if (!bw_n[k]) m[k*LANE_W +: LANE_W] = w[k*LANE_W +: LANE_W];
      mem[ba(b, i)] = m;
    end
    @(negedge clk) d = DATA_W'({$urandom(), $urandom()});
    bw_n = 4'h0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] b);
    read_sel_n = 1'b0;
    shared_address = b;
    @(negedge clk) read_sel_n = 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) #1;
      if (i < 4) begin
        chk(q, mem[ba(b, i)]);
        chk(DATA_W'(q_oe), 36'h000000001);
      end else begin
        chk(DATA_W'(q_oe), 36'h000000000);
      end
      if (i > 0) begin
        chk(q_n, mem[ba(b, i - 1)] & NARROW_MASK);
        chk(DATA_W'(q_oe_n), 36'h000000001);
      end
    end
    repeat (2) @(negedge clk);
  endtask : rd
  initial begin
    #400000 fails++;
    summarize();
  end
  initial begin
    {srst, clock_run, read_sel_n, write_sel_n, bw_n} = 8'hff;
    shared_address = '0;
    d = '0;
    void'($urandom(50472));
    repeat (3) @(negedge clk);
    srst = 1'b0;
    for (int j = 0; j < 4; j++) begin
      a[j] = ADDR_W'($urandom());
      wr(a[j], 1'b0);
      rd(a[j]);
    end
    $display("Test full bursts done");
    for (int j = 0; j < 8; j++) begin
      wr(a[j % 4], 1'b1);
      rd(a[j % 4]);
    end
    $display("Test lane writes done");
    repeat (2100) @(negedge clk);
    chk(DATA_W'({impedance_settled, impedance_update, q_oe}), 36'h000000006);
    $display("Test idle settle done");
    clock_run = 1'b0;
    repeat (4) @(negedge clk);
    chk(DATA_W'({clock_stopped, q_oe}), 36'h000000002);
    clock_run = 1'b1;
    repeat (2) @(negedge clk);
    chk(DATA_W'(clock_stopped), 36'h000000000);
    $display("Test clock stop done");
    fork
      rd(a[0]);
      begin
        @(negedge clk) clock_run = 1'b0;
      end
    join
    chk(DATA_W'({clock_stopped, q_oe, q_oe_n}), 36'h000000004);
    chk(q, mem[ba(a[0], 3)]);
    chk(q_n, mem[ba(a[0], 3)] & NARROW_MASK);
    $display("Test stop during burst done");
    summarize();
  end
endmodule : testbench
bind qrbsp_port qrbsp_monitor u_mon (.clk(clk), .srst(srst), .clock_run(clock_run),
  .out_clk(out_clk), .out_clk_n(out_clk_n), .read_sel_n(read_sel_n),
  .write_sel_n(write_sel_n), .q(q), .q_oe(q_oe), .clock_stopped(clock_stopped),
  .impedance_update(impedance_update), .impedance_settled(impedance_settled));
`default_nettype wire
